// [bench/sleep_wake_sequencer_checker.sv]
// port-level assertions for the sleep entry and wake-up sequencer
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_sequencer_checker (
    input wire logic                              pclk,
    input wire logic                              presetn,
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic                              pwrite,
    input wire logic [sleep_wake_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                       pwdata,
    input wire logic [31:0]                       prdata,
    input wire logic                              pready,
    input wire logic                              pslverr,
    input wire logic                              wake_pin,
    input wire logic                              device_sleep,
    input wire logic                              main_osc_enable,
    input wire logic                              main_clock_stable,
    input wire logic                              radio_fsm_reset,
    input wire logic                              force_transmit_state,
    input wire logic                              force_receive_state
);
    localparam logic [sleep_wake_pkg::ADDR_W-1:0] A_SLP = {sleep_wake_pkg::SLEEP_REQ_IDX, 2'b00};
    localparam logic [sleep_wake_pkg::ADDR_W-1:0] A_CTL = {sleep_wake_pkg::RADIO_CTL_IDX, 2'b00};
    logic acc;
    logic mapped;
    assign acc    = psel && penable;
    assign mapped = paddr inside {A_SLP, A_CTL, {sleep_wake_pkg::LP_CLK_SEL_IDX, 2'b00},
                    {sleep_wake_pkg::LP_CLK_DIV_IDX, 2'b00}, {sleep_wake_pkg::STATUS_IDX, 2'b00}};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_sleep_entry;
        acc && pwrite && paddr == A_SLP && pwdata[7] && !device_sleep && main_clock_stable
        |=> device_sleep && !main_osc_enable && !main_clock_stable;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep request not taken");
    property p_req_reads_zero;
        psel && !penable && !pwrite && paddr == A_SLP |=> !prdata[7];
    endproperty
    a_req_reads_zero: assert property (p_req_reads_zero) else $error("sleep request bit reads one");
    property p_stay_asleep;
        device_sleep && !wake_pin && !$past(wake_pin) && !$past(wake_pin, 2) && !$past(wake_pin, 3) |=> device_sleep;
    endproperty
    a_stay_asleep: assert property (p_stay_asleep) else $error("left sleep without wake");
    property p_osc_off_asleep;
        device_sleep |-> !main_osc_enable && !main_clock_stable;
    endproperty
    a_osc_off_asleep: assert property (p_osc_off_asleep) else $error("oscillator on in sleep");
    property p_stable_after_osc;
        $rose(main_clock_stable) |-> main_osc_enable && !device_sleep;
    endproperty
    a_stable_after_osc: assert property (p_stable_after_osc) else $error("stable without oscillator");
    property p_wake_waits;
        $rose(main_osc_enable) |-> $past(device_sleep) && !main_clock_stable;
    endproperty
    a_wake_waits: assert property (p_wake_waits) else $error("clock stable at wake start");
    property p_mode_bits;
        acc && pwrite && paddr == A_CTL |=> {radio_fsm_reset, force_transmit_state, force_receive_state}
            == $past(pwdata[2:0]);
    endproperty
    a_mode_bits: assert property (p_mode_bits) else $error("mode control outputs wrong");
    property p_unmapped_err;
        acc |-> pslverr == !mapped;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("error response wrong");
    property p_ready_high;
        psel |-> pready && prdata[31:8] == 24'h0;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("ready low or upper data set");

    c_sleep: cover property ($rose(device_sleep));
    c_stable: cover property ($rose(main_clock_stable));
    c_err: cover property (acc && pslverr);
endmodule // sleep_wake_sequencer_checker

bind sleep_wake_sequencer sleep_wake_sequencer_checker
    checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_pin(wake_pin), .device_sleep(device_sleep),
    .main_osc_enable(main_osc_enable), .main_clock_stable(main_clock_stable),
    .radio_fsm_reset(radio_fsm_reset), .force_transmit_state(force_transmit_state),
    .force_receive_state(force_receive_state));
`default_nettype wire

// [bench/sleep_wake_sequencer_tb.sv]
// self-checking testbench for the sleep entry and wake-up sequencer
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_sequencer_tb;
    localparam logic [9:0] A_SLP = {sleep_wake_pkg::SLEEP_REQ_IDX, 2'b00};
    localparam logic [9:0] A_CTL = {sleep_wake_pkg::RADIO_CTL_IDX, 2'b00};
    localparam logic [9:0] A_SEL = {sleep_wake_pkg::LP_CLK_SEL_IDX, 2'b00};
    localparam logic [9:0] A_DIV = {sleep_wake_pkg::LP_CLK_DIV_IDX, 2'b00};
    localparam logic [9:0] A_STA = {sleep_wake_pkg::STATUS_IDX, 2'b00};
    localparam int         CAL   = 20;
    localparam int         BASE  = 4;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic        wake_pin = 1'b0, ext_clock_pin = 1'b0, e;
    logic [2:0]  ext_div = '0;
    logic        pready, pslverr, device_sleep, main_osc_enable, main_clock_stable;
    logic        radio_fsm_reset, force_transmit_state, force_receive_state;
    int          num_errors = 0, n_compared = 0;

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        ext_div <= ext_div + 3'd1;
        ext_clock_pin <= ext_div[2];
    end

    sleep_wake_sequencer #(.CAL_CYCLES(CAL), .LP_BASE_CYCLES(BASE)) sleep_wake_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
        .ext_clock_pin(ext_clock_pin), .device_sleep(device_sleep), .main_osc_enable(main_osc_enable),
        .main_clock_stable(main_clock_stable), .radio_fsm_reset(radio_fsm_reset),
        .force_transmit_state(force_transmit_state), .force_receive_state(force_receive_state));

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic bound_hit(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            $display("FAIL %0t wait ran out", $time);
            summarize();
        end
    endtask
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        bound_hit(n, 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input string what);
        apb(1'b0, a, 32'h0, r, e);
        check(r, {24'h0, exp}, what);
        check(e, 1'b0, what);
    endtask
    task automatic sleep_wake(input logic [1:0] sel, input logic [4:0] div, input logic [8:0] cnt, input int per);
        int m, exp, slack;
        wr(A_SEL, {sel, 6'h0});
        wr(A_DIV, {3'h0, div});
        wr(A_CTL, {3'h0, cnt[8:7], 3'h0});
        wr(A_SLP, {1'b1, cnt[6:0]});
        @(posedge pclk);
        check({device_sleep, main_osc_enable, main_clock_stable}, 3'b100, "sleep outputs");
        rd_chk(A_SLP, {1'b0, cnt[6:0]}, "request self-clears");
        rd_chk(A_CTL, {3'h0, cnt[8:7], 3'h0}, "count high bits");
        rd_chk(A_STA, 8'h01, "status asleep");
        wake_pin <= 1'b1;
        m = 0;
        while (main_osc_enable !== 1'b1 && m < 20) begin
            @(posedge pclk);
            m++;
        end
        bound_hit(m, 20);
        m = 0;
        while (main_clock_stable !== 1'b1 && m < 5000) begin
            @(posedge pclk);
            m++;
        end
        bound_hit(m, 5000);
        exp = int'(cnt) * (int'(div) + 1) * per;
        // an external source keeps its own phase
        slack = (sel == sleep_wake_pkg::LP_SEL_EXTERNAL) ? (int'(div) + 1) * per : 0;
        check(m >= exp - slack && m <= exp + 4, 1'b1, "wake delay length");
        wake_pin <= 1'b0;
        check({device_sleep, main_osc_enable}, 2'b01, "running after wake");
        rd_chk(A_STA, 8'h02, "status stable");
        $display("test wake count %0d done", cnt);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        check({device_sleep, main_osc_enable, main_clock_stable, radio_fsm_reset, force_transmit_state,
               force_receive_state}, 6'b011000, "reset outputs");
        rd_chk(A_SLP, 8'h00, "count low reset");
        rd_chk(A_CTL, 8'h00, "mode control reset");
        rd_chk(A_SEL, 8'h00, "select reset");
        rd_chk(A_DIV, 8'h00, "divider reset");
        rd_chk(A_STA, 8'h02, "status reset");
        $display("test reset done");
        wr(A_SLP, 8'h5F);
        rd_chk(A_SLP, 8'h5F, "recommended count");
        wr(A_CTL, 8'hFF);
        rd_chk(A_CTL, 8'h1F, "reserved bits read zero");
        wr(A_SEL, 8'hFF);
        rd_chk(A_SEL, 8'hC0, "select field");
        wr(A_DIV, 8'hFF);
        rd_chk(A_DIV, 8'h1F, "divider field");
        wr(A_STA, 8'hFF);
        rd_chk(A_STA, 8'h06, "status ignores writes");
        apb(1'b1, 10'h200, 32'h0000_00FF, r, e);
        check(e, 1'b1, "unmapped write error");
        apb(1'b0, 10'h0DC, 32'h0, r, e);
        check(e, 1'b1, "unmapped read");
        check(r, 32'h0, "unmapped data");
        $display("test registers done");
        wr(A_CTL, 8'h06);
        @(posedge pclk);
        check({radio_fsm_reset, force_transmit_state, force_receive_state}, 3'b110, "reset mode");
        wr(A_CTL, 8'h02);
        @(posedge pclk);
        check({radio_fsm_reset, force_transmit_state, force_receive_state}, 3'b010, "transmit mode");
        rd_chk(A_STA, 8'h06, "calibrating");
        repeat (CAL + 5) @(posedge pclk);
        rd_chk(A_STA, 8'h02, "calibration over");
        wr(A_CTL, 8'h01);
        @(posedge pclk);
        check({radio_fsm_reset, force_transmit_state, force_receive_state}, 3'b001, "receive mode");
        $display("test radio modes done");
        sleep_wake(2'h0, 5'h00, 9'h000, BASE);
        sleep_wake(2'h0, 5'h00, 9'h005, BASE);
        sleep_wake(2'h0, 5'h02, 9'h083, BASE);
        sleep_wake(2'h3, 5'h00, 9'h105, BASE);
        sleep_wake(2'h2, 5'h03, 9'h002, BASE);
        sleep_wake(sleep_wake_pkg::LP_SEL_EXTERNAL, 5'h01, 9'h003, 8);
        summarize();
    end
endmodule // sleep_wake_sequencer_tb
`default_nettype wire

// [src/low_power_tick_gen.sv]
// low-power clock enable generator: source select and divisor
`timescale 1ns/1ps
`default_nettype none
module low_power_tick_gen #(
    parameter int unsigned BASE_CYCLES = sleep_wake_pkg::LP_BASE_CYCLES
) (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic                                 restart,
    input  wire logic [sleep_wake_pkg::LP_SEL_W-1:0]  low_power_clock_select,
    input  wire logic [sleep_wake_pkg::LP_DIV_W-1:0]  low_power_clock_divider,
    input  wire logic                                 ext_clock_pin,
    output logic                                      tick
);
    localparam int unsigned BW = $clog2(BASE_CYCLES + 1);

    if (BASE_CYCLES < 2) begin : g_check
        $error("BASE_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic [1:0]                          pin_sync;
        logic                                pin_prev;
        logic [BW-1:0]                       base_cnt;
        logic [sleep_wake_pkg::LP_DIV_W-1:0] div_cnt;
        logic                                tick;
    } tick_state_t;

    tick_state_t s;
    tick_state_t n;

    always_comb begin
        logic src_tick;
        src_tick   = 1'b0;
        n          = s;
        n.tick     = 1'b0;
        n.pin_sync = {s.pin_sync[0], ext_clock_pin};
        n.pin_prev = s.pin_sync[1];
        if (s.base_cnt == BW'(BASE_CYCLES - 1)) begin
            n.base_cnt = '0;
        end else begin
            n.base_cnt = s.base_cnt + 1'b1;
        end
        // source select picks the raw sleep clock
        if (low_power_clock_select == sleep_wake_pkg::LP_SEL_EXTERNAL) begin
            src_tick = s.pin_sync[1] & ~s.pin_prev;
        end else begin
            src_tick = (s.base_cnt == BW'(BASE_CYCLES - 1));
        end
        // divisor stretches the period to divider+1 source periods
        if (src_tick) begin
            if (s.div_cnt >= low_power_clock_divider) begin
                n.div_cnt = '0;
                n.tick    = 1'b1;
            end else begin
                n.div_cnt = s.div_cnt + 1'b1;
            end
        end
        // realign the base phase so the first wake period is a whole one for the internal source; an external pin keeps its own phase
        if (restart) begin
            n.base_cnt = '0;
            n.div_cnt  = '0;
            n.tick     = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;

endmodule // low_power_tick_gen
`default_nettype wire

// [src/sleep_wake_pkg.sv]
// constants, types and helpers shared by the sleep entry and wake-up sequencer
package sleep_wake_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] SLEEP_REQ_IDX   = 8'h35;
    localparam logic [7:0] RADIO_CTL_IDX   = 8'h36;
    localparam logic [7:0] LP_CLK_SEL_IDX  = 8'h40;
    localparam logic [7:0] LP_CLK_DIV_IDX  = 8'h41;
    localparam logic [7:0] STATUS_IDX      = 8'h42;

    localparam int unsigned ADDR_W = 10;

    // sleep request register fields
    localparam int unsigned SLEEP_REQ_BIT  = 7;
    localparam int unsigned WAKE_LOW_W     = 7;

    // radio mode control register fields
    localparam int unsigned WAKE_HIGH_POS  = 3;
    localparam int unsigned WAKE_HIGH_W    = 2;
    localparam int unsigned RF_RESET_BIT   = 2;
    localparam int unsigned FORCE_TX_BIT   = 1;
    localparam int unsigned FORCE_RX_BIT   = 0;

    // low-power clock configuration fields
    localparam int unsigned LP_SEL_POS     = 6;
    localparam int unsigned LP_SEL_W       = 2;
    localparam int unsigned LP_DIV_W       = 5;

    // status register fields
    localparam int unsigned ST_ASLEEP_BIT  = 0;
    localparam int unsigned ST_STABLE_BIT  = 1;
    localparam int unsigned ST_CAL_BIT     = 2;
    localparam int unsigned ST_WAKING_BIT  = 3;

    localparam int unsigned WAKE_W = 9;

    // reset and recommended values
    localparam logic [WAKE_W-1:0]   WAKE_COUNT_RESET       = 9'h000;
    localparam logic [WAKE_W-1:0]   WAKE_COUNT_RECOMMENDED = 9'h05F;
    localparam logic [LP_SEL_W-1:0] LP_SEL_RESET           = 2'h0;
    localparam logic [LP_DIV_W-1:0] LP_DIV_RESET           = 5'h00;

    // low-power clock source encodings
    localparam logic [LP_SEL_W-1:0] LP_SEL_EXTERNAL = 2'h1;

    // timing
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned CAL_TIME_US       = 192;
    localparam int unsigned CAL_CYCLES        = (CAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LP_BASE_PERIOD_NS = 10000;
    localparam int unsigned LP_BASE_CYCLES    = LP_BASE_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_WAKE
    } power_state_t;

    function automatic logic [ADDR_W-1:0] reg_byte_addr(input logic [7:0] idx);
        reg_byte_addr = {idx, 2'b00};
    endfunction

endpackage

// [src/sleep_wake_sequencer.sv]
// sleep entry and wake-up sequencer with its register file on APB
//
// Overview of operation
// - nine-bit wake count, low seven bits here
// - wake count bits 8:7 in mode control 4:3
// - wake count times main oscillator start-up
// - one count unit is one sleep-clock period
// - wake count resets to zero
// - sleep clock from source select and divisor
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_sequencer #(
    parameter int unsigned CAL_CYCLES     = sleep_wake_pkg::CAL_CYCLES,
    parameter int unsigned LP_BASE_CYCLES = sleep_wake_pkg::LP_BASE_CYCLES
) (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [sleep_wake_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                       pwdata,
    output logic [31:0]                            prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic                              wake_pin,
    input  wire logic                              ext_clock_pin,
    output logic                                   device_sleep,
    output logic                                   main_osc_enable,
    output logic                                   main_clock_stable,
    output logic                                   radio_fsm_reset,
    output logic                                   force_transmit_state,
    output logic                                   force_receive_state
);
    localparam int unsigned CAL_W = $clog2(CAL_CYCLES + 1);

    if (CAL_CYCLES < 1) begin : g_check_cal
        $error("CAL_CYCLES must be at least 1");
    end

    typedef struct packed {
        sleep_wake_pkg::power_state_t               pwr;
        logic [1:0]                                 wake_sync;
        logic [sleep_wake_pkg::WAKE_W-1:0]          wake_delay_count;
        logic                                       radio_fsm_reset;
        logic                                       force_tx;
        logic                                       force_rx;
        logic [sleep_wake_pkg::LP_SEL_W-1:0]        lp_sel;
        logic [sleep_wake_pkg::LP_DIV_W-1:0]        lp_div;
        logic [CAL_W-1:0]                           cal_cnt;
        logic                                       asleep;
        logic                                       osc_en;
        logic                                       clock_stable;
        logic                                       timer_start;
        logic [31:0]                                prdata;
        logic                                       pslverr;
    } seq_state_t;

    seq_state_t s;
    seq_state_t n;

    logic lp_tick;
    logic timer_busy;
    logic timer_done;

    // address decode, used by the write, read and error paths
    function automatic logic addr_hit(input logic [sleep_wake_pkg::ADDR_W-1:0] a,
                                      input logic [7:0]                        idx);
        addr_hit = (a == sleep_wake_pkg::reg_byte_addr(idx));
    endfunction

    function automatic logic mapped(input logic [sleep_wake_pkg::ADDR_W-1:0] a);
        mapped = addr_hit(a, sleep_wake_pkg::SLEEP_REQ_IDX)
               | addr_hit(a, sleep_wake_pkg::RADIO_CTL_IDX)
               | addr_hit(a, sleep_wake_pkg::LP_CLK_SEL_IDX)
               | addr_hit(a, sleep_wake_pkg::LP_CLK_DIV_IDX)
               | addr_hit(a, sleep_wake_pkg::STATUS_IDX);
    endfunction

    always_comb begin
        logic                 wr;
        logic                 sleep_go;
        logic [7:0]           rd;
        logic [7:0]           wb;
        logic                 cal_busy;
        wr       = psel & penable & pwrite;
        sleep_go = 1'b0;
        rd       = 8'h00;
        wb       = pwdata[7:0];
        cal_busy = s.radio_fsm_reset | (s.cal_cnt != '0);
        n             = s;
        n.timer_start = 1'b0;
        n.wake_sync   = {s.wake_sync[0], wake_pin};

        // calibration hold-off counts down after the radio reset is released
        if (s.cal_cnt != '0) begin
            n.cal_cnt = s.cal_cnt - 1'b1;
        end

        // register writes land in the access phase; pready is always high
        if (wr) begin
            if (addr_hit(paddr, sleep_wake_pkg::SLEEP_REQ_IDX)) begin
                n.wake_delay_count[sleep_wake_pkg::WAKE_LOW_W-1:0] =
                    wb[sleep_wake_pkg::WAKE_LOW_W-1:0];
                sleep_go = wb[sleep_wake_pkg::SLEEP_REQ_BIT];
            end
            if (addr_hit(paddr, sleep_wake_pkg::RADIO_CTL_IDX)) begin
                n.wake_delay_count[sleep_wake_pkg::WAKE_W-1:sleep_wake_pkg::WAKE_LOW_W] =
                    wb[sleep_wake_pkg::WAKE_HIGH_POS +: sleep_wake_pkg::WAKE_HIGH_W];
                n.radio_fsm_reset = wb[sleep_wake_pkg::RF_RESET_BIT];
                n.force_tx        = wb[sleep_wake_pkg::FORCE_TX_BIT];
                n.force_rx        = wb[sleep_wake_pkg::FORCE_RX_BIT];
                // releasing the reset starts the calibration wait shown in status
                if (s.radio_fsm_reset && !wb[sleep_wake_pkg::RF_RESET_BIT]) begin
                    n.cal_cnt = CAL_W'(CAL_CYCLES);
                end
            end
            if (addr_hit(paddr, sleep_wake_pkg::LP_CLK_SEL_IDX)) begin
                n.lp_sel = wb[sleep_wake_pkg::LP_SEL_POS +: sleep_wake_pkg::LP_SEL_W];
            end
            if (addr_hit(paddr, sleep_wake_pkg::LP_CLK_DIV_IDX)) begin
                n.lp_div = wb[sleep_wake_pkg::LP_DIV_W-1:0];
            end
        end

        // read data and error are captured in the setup phase
        if (psel && !penable) begin
            if (addr_hit(paddr, sleep_wake_pkg::SLEEP_REQ_IDX)) begin
                // the request bit is self-clearing, so it always reads zero
                rd = {1'b0, s.wake_delay_count[sleep_wake_pkg::WAKE_LOW_W-1:0]};
            end else if (addr_hit(paddr, sleep_wake_pkg::RADIO_CTL_IDX)) begin
                rd = {3'b000,
                      s.wake_delay_count[sleep_wake_pkg::WAKE_W-1:sleep_wake_pkg::WAKE_LOW_W],
                      s.radio_fsm_reset, s.force_tx, s.force_rx};
            end else if (addr_hit(paddr, sleep_wake_pkg::LP_CLK_SEL_IDX)) begin
                rd = {s.lp_sel, 6'b00_0000};
            end else if (addr_hit(paddr, sleep_wake_pkg::LP_CLK_DIV_IDX)) begin
                rd = {3'b000, s.lp_div};
            end else if (addr_hit(paddr, sleep_wake_pkg::STATUS_IDX)) begin
                rd[sleep_wake_pkg::ST_ASLEEP_BIT] = s.asleep;
                rd[sleep_wake_pkg::ST_STABLE_BIT] = s.clock_stable;
                rd[sleep_wake_pkg::ST_CAL_BIT]    = cal_busy;
                rd[sleep_wake_pkg::ST_WAKING_BIT] = timer_busy;
            end
            n.prdata  = {24'h00_0000, rd};
            n.pslverr = ~mapped(paddr);
        end

        // power sequencing
        case (s.pwr)
            sleep_wake_pkg::PWR_RUN: begin
                if (sleep_go) begin
                    n.pwr          = sleep_wake_pkg::PWR_SLEEP;
                    n.asleep       = 1'b1;
                    n.osc_en       = 1'b0;
                    n.clock_stable = 1'b0;
                end
            end
            sleep_wake_pkg::PWR_SLEEP: begin
                // a wake level already high at entry wakes at once
                if (s.wake_sync[1]) begin
                    n.pwr         = sleep_wake_pkg::PWR_WAKE;
                    n.asleep      = 1'b0;
                    n.osc_en      = 1'b1;
                    n.timer_start = 1'b1;
                end
            end
            sleep_wake_pkg::PWR_WAKE: begin
                // main clock counts as usable only after the full start-up count
                if (timer_done) begin
                    n.pwr          = sleep_wake_pkg::PWR_RUN;
                    n.clock_stable = 1'b1;
                end
            end
            default: begin
                n.pwr          = sleep_wake_pkg::PWR_RUN;
                n.asleep       = 1'b0;
                n.osc_en       = 1'b1;
                n.clock_stable = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s                  <= '0;
            s.pwr              <= sleep_wake_pkg::PWR_RUN;
            s.wake_delay_count <= sleep_wake_pkg::WAKE_COUNT_RESET;
            s.lp_sel           <= sleep_wake_pkg::LP_SEL_RESET;
            s.lp_div           <= sleep_wake_pkg::LP_DIV_RESET;
            s.osc_en           <= 1'b1;
            s.clock_stable     <= 1'b1;
        end else begin
            s <= n;
        end
    end

    low_power_tick_gen #(
        .BASE_CYCLES (LP_BASE_CYCLES)
    ) low_power_tick_gen_inst (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .restart                 (s.timer_start),
        .low_power_clock_select  (s.lp_sel),
        .low_power_clock_divider (s.lp_div),
        .ext_clock_pin           (ext_clock_pin),
        .tick                    (lp_tick)
    );

    wake_delay_timer #(
        .COUNT_W (sleep_wake_pkg::WAKE_W)
    ) wake_delay_timer_inst (
        .pclk             (pclk),
        .presetn          (presetn),
        .start            (s.timer_start),
        .wake_delay_count (s.wake_delay_count),
        .tick             (lp_tick),
        .busy             (timer_busy),
        .done             (timer_done)
    );

    assign prdata               = s.prdata;
    assign pready               = 1'b1;
    assign pslverr              = s.pslverr & psel & penable;
    assign device_sleep         = s.asleep;
    assign main_osc_enable      = s.osc_en;
    assign main_clock_stable    = s.clock_stable;
    assign radio_fsm_reset      = s.radio_fsm_reset;
    assign force_transmit_state = s.force_tx;
    assign force_receive_state  = s.force_rx;

endmodule // sleep_wake_sequencer
`default_nettype wire

// [src/wake_delay_timer.sv]
// oscillator start-up timer counted in low-power clock periods
`timescale 1ns/1ps
`default_nettype none
module wake_delay_timer #(
    parameter int unsigned COUNT_W = sleep_wake_pkg::WAKE_W
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               start,
    input  wire logic [COUNT_W-1:0] wake_delay_count,
    input  wire logic               tick,
    output logic                    busy,
    output logic                    done
);
    if (COUNT_W < 1) begin : g_check
        $error("COUNT_W must be at least 1");
    end

    typedef struct packed {
        logic               busy;
        logic               done;
        logic [COUNT_W-1:0] remaining;
    } timer_state_t;

    timer_state_t s;
    timer_state_t n;

    always_comb begin
        n      = s;
        n.done = 1'b0;
        if (start) begin
            if (wake_delay_count == '0) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.busy      = 1'b1;
                n.remaining = wake_delay_count;
            end
        end else if (s.busy && tick) begin // one unit per sleep-clock period
            n.remaining = s.remaining - 1'b1;
            if (s.remaining == COUNT_W'(1)) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign busy = s.busy;
    assign done = s.done;

endmodule // wake_delay_timer
`default_nettype wire
